// file: hw/vsk_pkg.sv
`default_nettype none
package vsk_pkg;
    // Clock rate
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;

    // Feedback sampling period
    localparam int unsigned PERIOD_MS = 48;
    localparam int unsigned PERIOD_CYC = PERIOD_MS * CLK_KHZ;

    // Soft-start timing
    localparam int unsigned SOFT_MS = 12;
    localparam int unsigned SOFT_STEPS = 4;
    localparam int unsigned SOFT_STEP_CYC = SOFT_MS * CLK_KHZ / SOFT_STEPS;
    localparam logic [1:0] SOFT_STEP_FIRST = 2'h0;
    localparam logic [1:0] SOFT_STEP_LAST = 2'h3;
    localparam int unsigned CS_LIMIT_FIRST_MV = 320;
    localparam int unsigned CS_LIMIT_FINAL_MV = 1000;

    // Switch-on timing, plain defaults
    localparam int unsigned RING_NS = 2500;
    localparam int unsigned RING_CYC = (RING_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned MAX_OFF_US = 50;
    localparam int unsigned MAX_OFF_CYC = MAX_OFF_US * CLK_MHZ;

    // Valley-skip counter limits and valley counter maximum
    localparam logic [2:0] SKIP_MIN = 3'h1;
    localparam logic [2:0] SKIP_MAX = 3'h7;
    localparam logic [2:0] SKIP_RESET = 3'h1;
    localparam logic [2:0] VALLEY_MAX = 3'h7;

    // Comparator results, high while the named level is exceeded
    typedef struct packed {
        logic supply_on;
        logic line_high;
        logic fb_low_lo_line;
        logic fb_low_hi_line;
        logic fb_high_lo_line;
        logic fb_high_hi_line;
        logic fb_reset;
        logic valley_sense;
        logic switch_off;
    } vsk_cmp_type;

    typedef enum logic [2:0] {
        ST_OFF  = 3'h1,
        ST_SOFT = 3'h2,
        ST_RUN  = 3'h4
    } vsk_state_type;
endpackage
`default_nettype wire

// file: hw/vsk_sync.sv
`default_nettype none
module vsk_sync
    import vsk_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1 <= '0;
            dout <= '0;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: hw/vsk_valley_skip.sv
// Contract
// RULE_01: Evaluate feedback every 48 ms period
// RULE_02: Always below low: increment, max 7
// RULE_03: Above low, never high: hold value
// RULE_04: Above high, never reset: decrement, min 1
// RULE_05: Above reset threshold: force counter to 1
// RULE_06: Counter stays within 1 to 7
// RULE_07: Load counter with 1 at start-up
// RULE_08: Counter is valleys skipped before switch-on
// RULE_09: Low/high thresholds chosen by line level
// RULE_10: Soft-start 12 ms in four steps
// RULE_11: Current limit steps 0.32 V to 1 V
// RULE_12: Supply on: cell off, start soft-start
// RULE_13: Valleys turn on, comparator turns off
// RULE_14: Valley count 0..7, cleared at gate high
// RULE_15: After ringing time, on when count reached
// RULE_16: Max off time forces switch-on
// RULE_17: Synchronise comparators, sticky flags per period
`default_nettype none
module vsk_valley_skip
    import vsk_pkg::*;
#(
    parameter int unsigned P_PERIOD_CYC = PERIOD_CYC,
    parameter int unsigned P_SOFT_STEP_CYC = SOFT_STEP_CYC,
    parameter int unsigned P_MAX_OFF_CYC = MAX_OFF_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Comparator results
    input wire vsk_cmp_type cmp_in,
    // Switch and start-up control
    output logic gate_drive,
    output logic startup_cell_en,
    output logic soft_start_active,
    output logic [1:0] cs_limit_step,
    // Observed counters
    output logic [2:0] skip_count,
    output logic [2:0] valley_count
);
    function automatic logic pick_line(input logic lo_line, input logic hi_line,
                                       input logic line_high);
        pick_line = line_high ? hi_line : lo_line;
    endfunction

    vsk_cmp_type cmp;
    vsk_state_type state;
    logic [31:0] period_cnt;
    logic [31:0] soft_cnt;
    logic [31:0] off_cnt;
    logic saw_low;
    logic saw_high;
    logic saw_reset;
    logic valley_prev;
    logic above_low;
    logic above_high;
    logic eff_low;
    logic eff_high;
    logic eff_reset;
    logic period_end;
    logic running;
    logic valley_fall;
    logic turn_on;

    vsk_sync #(.WIDTH($bits(vsk_cmp_type))) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .din(cmp_in),
        .dout(cmp)
    ); // RULE_17

    assign above_low = pick_line(cmp.fb_low_lo_line, cmp.fb_low_hi_line, cmp.line_high); // RULE_09
    assign above_high = pick_line(cmp.fb_high_lo_line, cmp.fb_high_hi_line,
                                  cmp.line_high); // RULE_09
    assign eff_low = saw_low | above_low;
    assign eff_high = saw_high | above_high;
    assign eff_reset = saw_reset | cmp.fb_reset;
    assign running = (state != ST_OFF) && cmp.supply_on;
    assign period_end = running && (period_cnt == 32'(P_PERIOD_CYC - 1)); // RULE_01
    assign valley_fall = valley_prev && !cmp.valley_sense;
    // Ringing window first, then either enough valleys or the off-time watchdog
    assign turn_on = running && !gate_drive && !cmp.switch_off
                     && (off_cnt >= 32'(RING_CYC))
                     && ((valley_count >= skip_count)
                         || (off_cnt >= 32'(P_MAX_OFF_CYC - 1))); // RULE_15 RULE_16 RULE_08

    // Supply sequencing
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ST_OFF;
            soft_cnt <= 32'h0;
            cs_limit_step <= SOFT_STEP_FIRST;
            soft_start_active <= 1'b0;
            startup_cell_en <= 1'b1;
        end
        else if (!cmp.supply_on)
        begin
            state <= ST_OFF;
            soft_cnt <= 32'h0;
            cs_limit_step <= SOFT_STEP_FIRST;
            soft_start_active <= 1'b0;
            startup_cell_en <= 1'b1;
        end
        else
        begin
            unique case (state)
                ST_OFF:
                begin
                    state <= ST_SOFT; // RULE_12
                    startup_cell_en <= 1'b0; // RULE_12
                    soft_start_active <= 1'b1;
                    cs_limit_step <= SOFT_STEP_FIRST; // RULE_11
                    soft_cnt <= 32'h0;
                end
                ST_SOFT:
                begin
                    if (soft_cnt == 32'(P_SOFT_STEP_CYC - 1))
                    begin
                        soft_cnt <= 32'h0;
                        if (cs_limit_step == SOFT_STEP_LAST)
                        begin
                            state <= ST_RUN; // RULE_10
                            soft_start_active <= 1'b0;
                        end
                        else
                        begin
                            cs_limit_step <= cs_limit_step + 2'h1; // RULE_11
                        end
                    end
                    else
                    begin
                        soft_cnt <= soft_cnt + 32'h1; // RULE_10
                    end
                end
                ST_RUN:
                begin
                    cs_limit_step <= SOFT_STEP_LAST;
                end
            endcase
        end
    end

    // Sampling period and sticky comparator flags
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            period_cnt <= 32'h0;
            saw_low <= 1'b0;
            saw_high <= 1'b0;
            saw_reset <= 1'b0;
        end
        else if (!running)
        begin
            period_cnt <= 32'h0;
            saw_low <= 1'b0;
            saw_high <= 1'b0;
            saw_reset <= 1'b0;
        end
        else if (period_end)
        begin
            // Flags restart empty; an event on the boundary itself was already used
            period_cnt <= 32'h0;
            saw_low <= 1'b0; // RULE_17
            saw_high <= 1'b0;
            saw_reset <= 1'b0;
        end
        else
        begin
            period_cnt <= period_cnt + 32'h1;
            saw_low <= eff_low; // RULE_17
            saw_high <= eff_high;
            saw_reset <= eff_reset;
        end
    end

    // Valley-skip counter
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            skip_count <= SKIP_RESET;
        end
        else if (!running)
        begin
            skip_count <= SKIP_RESET; // RULE_07
        end
        else if (cmp.fb_reset)
        begin
            skip_count <= SKIP_RESET; // RULE_05
        end
        else if (period_end)
        begin
            if (eff_reset)
            begin
                skip_count <= SKIP_RESET; // RULE_05
            end
            else if (eff_high)
            begin
                if (skip_count > SKIP_MIN)
                begin
                    skip_count <= skip_count - 3'h1; // RULE_04 RULE_06
                end
            end
            else if (!eff_low) // RULE_03
            begin
                if (skip_count < SKIP_MAX)
                begin
                    skip_count <= skip_count + 3'h1; // RULE_02 RULE_06
                end
            end
        end
    end

    // Gate drive, valley counting and off-time
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gate_drive <= 1'b0;
            valley_count <= 3'h0;
            off_cnt <= 32'h0;
            valley_prev <= 1'b0;
        end
        else
        begin
            valley_prev <= cmp.valley_sense;
            if (!running)
            begin
                gate_drive <= 1'b0;
                valley_count <= 3'h0;
                off_cnt <= 32'h0;
            end
            else if (gate_drive)
            begin
                off_cnt <= 32'h0;
                valley_count <= 3'h0;
                if (cmp.switch_off)
                begin
                    gate_drive <= 1'b0; // RULE_13
                end
            end
            else if (turn_on)
            begin
                gate_drive <= 1'b1; // RULE_13
                valley_count <= 3'h0; // RULE_14
                off_cnt <= 32'h0;
            end
            else
            begin
                if (off_cnt < 32'(P_MAX_OFF_CYC - 1))
                begin
                    off_cnt <= off_cnt + 32'h1;
                end
                if (valley_fall && valley_count < VALLEY_MAX)
                begin
                    valley_count <= valley_count + 3'h1; // RULE_14
                end
            end
        end
    end

    AST_SKIP_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_06
        skip_count >= SKIP_MIN && skip_count <= SKIP_MAX)
        else $error("skip counter out of range");
    AST_INC: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_02
        period_end && cmp.supply_on && !eff_low && !eff_high && !eff_reset
        && skip_count < SKIP_MAX |=> skip_count == $past(skip_count) + 3'h1)
        else $error("skip counter did not increment");
    AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_03
        period_end && cmp.supply_on && eff_low && !eff_high && !eff_reset
        |=> $stable(skip_count))
        else $error("skip counter changed on hold");
    AST_DEC: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_04
        period_end && cmp.supply_on && eff_high && !eff_reset && skip_count > SKIP_MIN
        |=> skip_count == $past(skip_count) - 3'h1)
        else $error("skip counter did not decrement");
    AST_FORCE: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_05
        cmp.fb_reset |=> skip_count == SKIP_RESET)
        else $error("skip counter not forced to one");
    AST_MID_PERIOD: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_01
        running && cmp.supply_on && !period_end && !cmp.fb_reset |=> $stable(skip_count))
        else $error("skip counter moved inside a period");
    AST_STARTUP: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_07
        state == ST_OFF |-> skip_count == SKIP_RESET)
        else $error("skip counter not one at start-up");
    AST_VALLEY_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_14
        $rose(gate_drive) |-> valley_count == 3'h0)
        else $error("valley count not cleared at switch-on");
    AST_RING: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_15
        !gate_drive && off_cnt < 32'(RING_CYC) |=> !gate_drive)
        else $error("switch-on inside ringing window");
    AST_SOFT_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_11
        $rose(soft_start_active) |-> cs_limit_step == SOFT_STEP_FIRST && !startup_cell_en)
        else $error("soft-start did not begin at first step");
    AST_CELL: assert property (@(posedge clk_sys) disable iff (!rst_b) // RULE_12
        startup_cell_en |-> !gate_drive && !soft_start_active)
        else $error("switching while start-up cell is on");
endmodule
`default_nettype wire

// file: tb/vsk_partner.sv
`default_nettype none
module vsk_partner
#(
    parameter int ON_CYC = 20,
    parameter int HALF_CYC = 30
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Switch and winding
    input wire logic gate_drive,
    input wire logic [3:0] valley_num,
    output logic valley_sense,
    output logic switch_off
);
    timeunit 1ns;
    timeprecision 1ps;
    int on_cnt;
    int ring_cnt;

    // Sense trips a fixed time into each on-phase
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            on_cnt <= 0;
            switch_off <= 1'b0;
        end
        else
        begin
            on_cnt <= gate_drive ? on_cnt + 1 : 0;
            switch_off <= gate_drive && on_cnt >= ON_CYC;
        end
    end

    // Ringing after turn-off, one falling edge per valley
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ring_cnt <= 0;
            valley_sense <= 1'b0;
        end
        else
        begin
            ring_cnt <= gate_drive ? 0 : ring_cnt + 1;
            valley_sense <= !gate_drive && ring_cnt < 2 * HALF_CYC * int'(valley_num)
                && (ring_cnt / HALF_CYC) % 2 == 0;
        end
    end
endmodule
`default_nettype wire

// file: tb/vsk_tb_top.sv
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module valley_skip_frequency_reduction_tb_top
    import vsk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAX_OFF = 600;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    // Feedback between thresholds while soft-start runs
    vsk_cmp_type cmp_drv = 9'h040;
    vsk_cmp_type cmp_in;
    logic gate_drive, startup_cell_en, soft_start_active, valley_sense, switch_off;
    logic [1:0] cs_limit_step;
    logic [2:0] skip_count, valley_count, exp_skip;
    logic [3:0] valley_num = 4'h0;
    int err_count = 0;
    int tests_run = 0;
    int prev_lvl = 1;
    int seq[22] = '{0, 0, 0, 0, 0, 0, 1, 2, 2, 2, 2, 2, 2, 2, 0, 0, 0, 2, 1, 0, 0, 3};

    initial forever #2.5 clk_sys = ~clk_sys;

    always_comb
    begin
        cmp_in = cmp_drv;
        cmp_in.valley_sense = valley_sense;
        cmp_in.switch_off = switch_off;
    end

    vsk_valley_skip #(.P_PERIOD_CYC(200), .P_SOFT_STEP_CYC(50), .P_MAX_OFF_CYC(MAX_OFF)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .cmp_in(cmp_in), .gate_drive(gate_drive),
        .startup_cell_en(startup_cell_en), .soft_start_active(soft_start_active),
        .cs_limit_step(cs_limit_step), .skip_count(skip_count), .valley_count(valley_count));

    vsk_partner i_partner (.clk_sys(clk_sys), .rst_b(rst_b), .gate_drive(gate_drive),
        .valley_num(valley_num), .valley_sense(valley_sense), .switch_off(switch_off));

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask

    task automatic end_of_test();
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wait_gate(input logic lvl);
        int n;
        n = 0;
        while (gate_drive !== lvl)
        begin
            tick();
            n++;
            if (n > 800)
            begin
                err_count++;
                end_of_test();
            end
        end
    endtask

    // Other line's comparators stay quiet so a wrong selection shows
    task automatic drive(input int lvl, input logic lh);
        @(posedge clk_sys);
        cmp_drv.line_high <= lh;
        cmp_drv.fb_low_lo_line <= !lh && lvl >= 1;
        cmp_drv.fb_low_hi_line <= lh && lvl >= 1;
        cmp_drv.fb_high_lo_line <= !lh && lvl >= 2;
        cmp_drv.fb_high_hi_line <= lh && lvl >= 2;
        cmp_drv.fb_reset <= lvl == 3;
        #1;
    endtask

    task automatic soft_start();
        @(posedge clk_sys);
        cmp_drv.supply_on <= 1'b1;
        repeat (3) tick();
        `CHK({startup_cell_en, soft_start_active, cs_limit_step}, 4'h4)
        for (int s = 1; s < 4; s++)
        begin
            repeat (50) tick();
            `CHK(cs_limit_step, 2'(s))
        end
        repeat (50) tick();
        `CHK({soft_start_active, cs_limit_step}, 3'h3)
    endtask

    // Supply loss mid-run: gate, counters and soft-start all drop back together
    task automatic supply_drop();
        @(posedge clk_sys);
        cmp_drv.supply_on <= 1'b0;
        repeat (3) tick();
        `CHK({gate_drive, startup_cell_en, soft_start_active, cs_limit_step}, 5'h08)
        `CHK({skip_count, valley_count}, 6'h08)
    endtask

    // Level changes mid-period, so a period sees the old and the new level
    task automatic period(input int lvl, input logic lh);
        int cat;
        logic [2:0] cur;
        cur = exp_skip;
        cat = (lvl > prev_lvl) ? lvl : prev_lvl;
        prev_lvl = lvl;
        exp_skip = (cat == 3) ? 3'h1 : (cat == 2) ? ((cur > 3'h1) ? cur - 3'h1 : cur) :
            (cat == 1) ? cur : ((cur < 3'h7) ? cur + 3'h1 : cur);
        repeat (100) tick();
        drive(lvl, lh);
        repeat (9) tick();
        if (lvl == 3)
            `CHK(skip_count, 3'h1)
        repeat (89) tick();
        if (lvl != 3)
            `CHK(skip_count, cur)
        tick();
        `CHK(skip_count, exp_skip)
    endtask

    task automatic gate_cycle(input logic [3:0] nv);
        int n;
        logic [2:0] vc;
        logic [2:0] nvc;
        n = 0;
        vc = 3'h0;
        nvc = (nv > 4'h7) ? 3'h7 : nv[2:0];
        valley_num = nv;
        wait_gate(1'b1);
        wait_gate(1'b0);
        while (gate_drive === 1'b0 && n < 700)
        begin
            vc = valley_count;
            n++;
            tick();
        end
        `CHK(n, (nvc >= exp_skip) ? int'(RING_CYC) + 1 : MAX_OFF)
        `CHK(vc, nvc)
        `CHK(valley_count, 3'h0)
    endtask

    initial
    begin
        int n;
        tick();
        `CHK(skip_count, SKIP_RESET)
        `CHK({gate_drive, startup_cell_en, soft_start_active}, 3'h2)
        @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        soft_start();
        drive(0, 1'b0);
        n = 0;
        while (skip_count === 3'h1 && n < 450)
        begin
            tick();
            n++;
        end
        if (n == 450)
        begin
            err_count++;
            end_of_test();
        end
        `CHK(skip_count, 3'h2)
        exp_skip = 3'h2;
        prev_lvl = 0;
        for (int i = 0; i < 22; i++)
            period(seq[i], i >= 16);
        gate_cycle(4'h0);
        gate_cycle(4'h1);
        drive(0, 1'b0);
        repeat (1600) tick();
        exp_skip = 3'h7;
        `CHK(skip_count, exp_skip)
        gate_cycle(4'h5);
        gate_cycle(4'h9);
        supply_drop();
        soft_start();
        end_of_test();
    end
endmodule
`default_nettype wire
